// ==== common/cbx_pkg.sv ====
package cbx_pkg;
  // Clocks per machine cycle; a step counts clocks within one instruction
  localparam int         CLKS_PER_CYCLE = 3;
  localparam logic [2:0] LAST_ONE       = 3'(CLKS_PER_CYCLE - 1);
  localparam logic [2:0] LAST_TWO       = 3'(2 * CLKS_PER_CYCLE - 1);
  localparam logic [2:0] STEP_RD0       = 3'h0;
  localparam logic [2:0] STEP_RD1       = 3'h1;
  localparam logic [2:0] STEP_BIT_WR    = 3'h2;
  localparam logic [2:0] STEP_DEC_WR    = 3'h3;
  localparam logic [2:0] STEP_PUSH0     = 3'h3;
  localparam logic [2:0] STEP_PUSH1     = 3'h4;
  localparam logic [2:0] STEP_XD_ON     = 3'h1;
  localparam logic [2:0] STEP_XD_OFF    = 3'h4;
  localparam logic [2:0] STEP_CODE_RQ   = 3'h1;
  localparam logic [2:0] STEP_CODE_CAP  = 3'h3;
  // Addresses, reset values and field positions
  localparam logic [7:0] ADDR_ACC       = 8'he0;
  localparam logic [7:0] ADDR_STATUS    = 8'hd0;
  localparam logic [7:0] SP_RESET       = 8'h07;
  localparam logic [7:0] SP_PAIR        = 8'h02;
  localparam logic [3:0] BIT_RAM_BASE   = 4'h2;
  localparam logic [3:0] ABS_LOW        = 4'h1;
  localparam logic [15:0] LEN1          = 16'h0001;
  localparam logic [15:0] LEN2          = 16'h0002;
  localparam logic [15:0] LEN3          = 16'h0003;
  localparam int         ST_CY          = 7;
  localparam int         ST_RS_HI       = 4;
  localparam int         ST_RS_LO       = 3;
  localparam int         ABS_CALL_BIT   = 4;
  // Opcodes
  localparam logic [7:0] OP_XD_RD_IDX = 8'he2, OP_XD_RD_DP = 8'he0, OP_XD_WR_IDX = 8'hf2,
                         OP_XD_WR_DP = 8'hf0, OP_CCR_DP = 8'h93, OP_CCR_PC = 8'h83,
                         OP_AND_C_BIT = 8'h82, OP_AND_C_NBIT = 8'hb0, OP_OR_C_BIT = 8'h72,
                         OP_OR_C_NBIT = 8'ha0, OP_MOV_C_BIT = 8'ha2, OP_MOV_BIT_C = 8'h92,
                         OP_CLR_C = 8'hc3, OP_CLR_BIT = 8'hc2, OP_SET_C = 8'hd3,
                         OP_SET_BIT = 8'hd2, OP_INV_C = 8'hb3, OP_INV_BIT = 8'hb2,
                         OP_JMP_CY = 8'h40, OP_JMP_NCY = 8'h50, OP_JMP_BIT = 8'h20,
                         OP_JMP_NBIT = 8'h30, OP_JMP_BITCLR = 8'h10, OP_JMP_ACCZ = 8'h60,
                         OP_JMP_ACCNZ = 8'h70, OP_JMP_SHORT = 8'h80, OP_JMP_LONG = 8'h02,
                         OP_CALL_LONG = 8'h12, OP_JMP_IND = 8'h73, OP_SUB_RTN = 8'h22,
                         OP_INT_RTN = 8'h32, OP_NO_OP = 8'h00, OP_DEC_BR_DIR = 8'hd5,
                         OP_DEC_BR_REG = 8'hd8, OP_CMP_BR_AIMM = 8'hb4,
                         OP_CMP_BR_ADIR = 8'hb5, OP_CMP_BR_IDX = 8'hb6,
                         OP_CMP_BR_REG = 8'hb8;
  typedef struct packed {
    logic [7:0] op;
    logic [7:0] b1;
    logic [7:0] b2;
  } cbx_ins_t;
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } cbx_xbus_t;
  typedef enum logic [1:0] {
    ST_WAIT = 2'b01,
    ST_EXEC = 2'b10
  } cbx_state_t;
endpackage : cbx_pkg

// ==== rtl/cbx_iram.sv ====
`timescale 1ns/1ps
module cbx_iram
  import cbx_pkg::*;
#(
  parameter int AW = 8,
  parameter int DW = 8
) (
  // Clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_rst_n,
  // Single access port, read data one clock later
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_addr,
  input  wire logic [DW-1:0] i_wdata,
  output logic      [DW-1:0] o_rdata
);
  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= mem[i_addr];
    end
  end
endmodule : cbx_iram

// ==== rtl/cbx_exec.sv ====
// Notes on behaviour
// RQ1: External moves address via index register (8 bits) or data pointer (16 bits).
// RQ2: Every external data move completes in two machine cycles.
// RQ3: Accumulator alone supplies write data and receives read data externally.
// RQ4: External read and write strobes appear only during external data moves.
// RQ5: Code read loads accumulator from acc plus data pointer or PC, two cycles.
// RQ6: Bit addresses below 80H map to lower RAM bits, the rest to SFRs.
// RQ7: Carry is the bit accumulator; and, or, move, clear, set, invert take one cycle.
// RQ8: Bit operands are direct only; no exclusive-or on bits.
// RQ9: Jump on bit and clear branches on one, clears the bit, two cycles.
// RQ10: Taken relative branch adds signed offset to the following instruction address.
// RQ11: Short relative jump is opcode plus one offset byte.
// RQ12: Long jump is three bytes carrying a full 16-bit target.
// RQ13: Page jump replaces low 11 PC bits, keeps top five bits.
// RQ14: Indexed jump target is data pointer plus accumulator at run time.
// RQ15: Long call takes 16-bit address; page call stays in the same 2k block.
// RQ16: Interrupt return acts as subroutine return and signals interrupt done.
// RQ17: No zero flag; accumulator zero branches test the accumulator itself.
// RQ18: Decrement and branch decrements operand, branches when nonzero, two cycles.
// RQ19: Compare and branch jumps if bytes differ; carry set when first is less.
// RQ20: Jumps, calls and returns take two machine cycles; no operation takes one.
// RQ21: Decrement and branch wraps zero to 255 and leaves status flags alone.
`timescale 1ns/1ps
module cbx_exec
  import cbx_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // Instruction feed
  input  wire logic       i_ins_valid,
  input  wire cbx_ins_t   i_ins,
  output logic            o_ins_ready,
  // Data pointer load
  input  wire logic       i_data_ptr_ld,
  input  wire logic [15:0] i_data_ptr,
  // Program memory constant read
  output logic            o_code_rd,
  output logic [15:0]     o_code_addr,
  input  wire logic [7:0] i_code_data,
  // External data memory
  output cbx_xbus_t       o_xd,
  input  wire logic [7:0] i_xd_rdata,
  // Core state
  output logic [15:0]     o_pc,
  output logic [7:0]      o_acc,
  output logic [7:0]      o_status_word,
  output logic [7:0]      o_sp,
  output logic [15:0]     o_data_ptr,
  output logic            o_int_done
);
  cbx_state_t  state;
  cbx_ins_t    ins;
  logic [2:0]  step;
  logic [2:0]  last_step;
  logic        commit;
  logic [7:0]  op;
  logic [7:0]  opnd0;
  logic [7:0]  opnd1;
  logic [7:0]  xcap;
  logic [7:0]  ccap;
  logic        xd_rd, xd_wr, xd_dp, is_xmove, is_ccr;
  logic        idx_ind, reg_rn, is_abs, is_call, is_rtn, is_dec, is_cmp;
  logic        bit_data, bit_jump, byte_dir, dir_rd, one_cyc, one_byte, three_byte;
  logic        bit_wr, sfr_acc, sfr_st, sfr_hit;
  logic [1:0]  rs;
  logic [7:0]  bit_byte, rd0_addr, rd1_addr, rel, dec_val, cmp_a, cmp_b;
  logic [2:0]  bit_idx;
  logic        cy, bv, bv_new, taken, next_cy;
  logic [7:0]  byte_new;
  logic [15:0] pc_next, rel_target, next_pc;
  logic        m_we;
  logic [7:0]  m_addr, m_wdata, m_rdata;

  assign op = ins.op;
  assign cy = o_status_word[ST_CY];
  assign rs = o_status_word[ST_RS_HI:ST_RS_LO];

  // Instruction classes
  assign xd_rd      = (op == OP_XD_RD_DP) || (op[7:1] == OP_XD_RD_IDX[7:1]);
  assign xd_wr      = (op == OP_XD_WR_DP) || (op[7:1] == OP_XD_WR_IDX[7:1]);
  assign xd_dp      = (op == OP_XD_RD_DP) || (op == OP_XD_WR_DP); // RQ1
  assign is_xmove   = xd_rd || xd_wr;
  assign is_ccr     = (op == OP_CCR_DP) || (op == OP_CCR_PC);
  assign idx_ind    = (op[7:1] == OP_XD_RD_IDX[7:1]) || (op[7:1] == OP_XD_WR_IDX[7:1])
                   || (op[7:1] == OP_CMP_BR_IDX[7:1]);
  assign reg_rn     = (op[7:3] == OP_DEC_BR_REG[7:3]) || (op[7:3] == OP_CMP_BR_REG[7:3]);
  assign is_abs     = (op[3:0] == ABS_LOW);
  assign is_call    = (op == OP_CALL_LONG) || (is_abs && op[ABS_CALL_BIT]); // RQ15
  assign is_rtn     = (op == OP_SUB_RTN) || (op == OP_INT_RTN);
  assign is_dec     = (op == OP_DEC_BR_DIR) || (op[7:3] == OP_DEC_BR_REG[7:3]);
  assign is_cmp     = (op == OP_CMP_BR_AIMM) || (op == OP_CMP_BR_ADIR)
                   || (op[7:1] == OP_CMP_BR_IDX[7:1]) || (op[7:3] == OP_CMP_BR_REG[7:3]);
  assign bit_jump   = op inside {OP_JMP_BIT, OP_JMP_NBIT, OP_JMP_BITCLR};
  // Bit operands only ever come from a direct bit address; no xor form exists
  assign bit_data   = bit_jump || op inside {OP_AND_C_BIT, OP_AND_C_NBIT, OP_OR_C_BIT,
                      OP_OR_C_NBIT, OP_MOV_C_BIT, OP_MOV_BIT_C, OP_CLR_BIT, OP_SET_BIT,
                      OP_INV_BIT}; // RQ8
  assign byte_dir   = (op == OP_DEC_BR_DIR) || (op == OP_CMP_BR_ADIR);
  assign dir_rd     = bit_data || byte_dir;
  assign one_cyc    = (bit_data && !bit_jump)
                   || op inside {OP_CLR_C, OP_SET_C, OP_INV_C, OP_NO_OP}; // RQ7 RQ20
  assign one_byte   = is_xmove || is_ccr || op inside {OP_JMP_IND, OP_SUB_RTN, OP_INT_RTN,
                      OP_NO_OP, OP_CLR_C, OP_SET_C, OP_INV_C};
  assign three_byte = bit_jump || is_cmp
                   || op inside {OP_JMP_LONG, OP_CALL_LONG, OP_DEC_BR_DIR}; // RQ12
  assign last_step  = one_cyc ? LAST_ONE : LAST_TWO; // RQ2 RQ9 RQ18 RQ20
  assign commit     = (state == ST_EXEC) && (step == last_step);

  // Operand addressing
  assign bit_idx  = ins.b1[2:0];
  // Low bit addresses sit in the bit area of lower RAM, high ones in SFR bytes
  assign bit_byte = ins.b1[7] ? {ins.b1[7:3], 3'h0} : {BIT_RAM_BASE, ins.b1[6:3]}; // RQ6
  always_comb begin
    rd0_addr = o_sp;
    if (bit_data) begin
      rd0_addr = bit_byte;
    end else if (byte_dir) begin
      rd0_addr = ins.b1;
    end else if (reg_rn) begin
      rd0_addr = {3'h0, rs, op[2:0]};
    end else if (idx_ind) begin
      rd0_addr = {3'h0, rs, 2'h0, op[0]}; // RQ1
    end
  end
  assign rd1_addr = idx_ind ? m_rdata : o_sp - 8'h01;
  assign sfr_acc  = dir_rd && (rd0_addr == ADDR_ACC);
  assign sfr_st   = dir_rd && (rd0_addr == ADDR_STATUS);
  assign sfr_hit  = sfr_acc || sfr_st;
  assign bv       = opnd0[bit_idx];
  assign dec_val  = opnd0 - 8'h01; // RQ21
  assign cmp_a    = idx_ind ? opnd1 : (reg_rn ? opnd0 : o_acc);
  assign cmp_b    = (op == OP_CMP_BR_ADIR) ? opnd0 : ins.b1;
  assign bit_wr   = op inside {OP_MOV_BIT_C, OP_CLR_BIT, OP_SET_BIT, OP_INV_BIT}
                 || ((op == OP_JMP_BITCLR) && bv); // RQ9

  // Bit results, carry results and branch decision
  always_comb begin
    bv_new  = 1'b0;
    taken   = 1'b0;
    next_cy = cy;
    case (op)
      OP_AND_C_BIT:   next_cy = cy & bv; // RQ7
      OP_AND_C_NBIT:  next_cy = cy & ~bv;
      OP_OR_C_BIT:    next_cy = cy | bv;
      OP_OR_C_NBIT:   next_cy = cy | ~bv;
      OP_MOV_C_BIT:   next_cy = bv;
      OP_CLR_C:       next_cy = 1'b0;
      OP_SET_C:       next_cy = 1'b1;
      OP_INV_C:       next_cy = ~cy;
      OP_SET_BIT:     bv_new = 1'b1;
      OP_INV_BIT:     bv_new = ~bv;
      OP_MOV_BIT_C:   bv_new = cy;
      OP_JMP_CY:      taken = cy;
      OP_JMP_NCY:     taken = ~cy;
      OP_JMP_BIT:     taken = bv;
      OP_JMP_NBIT:    taken = ~bv;
      OP_JMP_BITCLR:  taken = bv; // RQ9
      OP_JMP_ACCZ:    taken = (o_acc == 8'h00); // RQ17
      OP_JMP_ACCNZ:   taken = (o_acc != 8'h00); // RQ17
      OP_JMP_SHORT:   taken = 1'b1; // RQ11
      default:        taken = 1'b0;
    endcase
    if (is_dec) begin
      taken = (dec_val != 8'h00); // RQ18
    end
    if (is_cmp) begin
      taken   = (cmp_a != cmp_b); // RQ19
      next_cy = (cmp_a < cmp_b);
    end
    byte_new          = opnd0;
    byte_new[bit_idx] = bv_new;
  end

  // Program counter targets
  assign pc_next    = o_pc + (one_byte ? LEN1 : (three_byte ? LEN3 : LEN2));
  assign rel        = three_byte ? ins.b2 : ins.b1;
  assign rel_target = pc_next + {{8{rel[7]}}, rel}; // RQ10
  always_comb begin
    next_pc = pc_next;
    if (taken) begin
      next_pc = rel_target; // RQ10
    end
    if ((op == OP_JMP_LONG) || (op == OP_CALL_LONG)) begin
      next_pc = {ins.b1, ins.b2}; // RQ12 RQ15
    end
    if (is_abs) begin
      next_pc = {pc_next[15:11], op[7:5], ins.b1}; // RQ13 RQ15
    end
    if (op == OP_JMP_IND) begin
      next_pc = o_data_ptr + {8'h00, o_acc}; // RQ14
    end
    if (is_rtn) begin
      next_pc = {opnd0, opnd1}; // RQ16
    end
  end

  // Internal RAM port: reads on the first two steps, writes later
  always_comb begin
    m_we    = 1'b0;
    m_addr  = rd0_addr;
    m_wdata = byte_new;
    if (step == STEP_RD1) begin
      m_addr = rd1_addr;
    end
    if (state == ST_EXEC) begin
      if ((step == STEP_BIT_WR) && bit_wr && !sfr_hit) begin
        m_we   = 1'b1;
        m_addr = rd0_addr;
      end
      if ((step == STEP_DEC_WR) && is_dec && !sfr_hit) begin
        m_we    = 1'b1;
        m_addr  = rd0_addr;
        m_wdata = dec_val; // RQ18
      end
      if (is_call && (step == STEP_PUSH0)) begin
        m_we    = 1'b1;
        m_addr  = o_sp + 8'h01;
        m_wdata = pc_next[7:0];
      end
      if (is_call && (step == STEP_PUSH1)) begin
        m_we    = 1'b1;
        m_addr  = o_sp + SP_PAIR;
        m_wdata = pc_next[15:8];
      end
    end
  end

  cbx_iram #(
    .AW (8),
    .DW (8)
  ) u_iram (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_we    (m_we),
    .i_addr  (m_addr),
    .i_wdata (m_wdata),
    .o_rdata (m_rdata)
  );

  // Sequencer
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state       <= ST_WAIT;
      o_ins_ready <= 1'b1;
      step        <= STEP_RD0;
      ins         <= '0;
    end else begin
      case (state)
        ST_WAIT: begin
          if (i_ins_valid) begin
            ins         <= i_ins;
            state       <= ST_EXEC;
            o_ins_ready <= 1'b0;
            step        <= STEP_RD0;
          end
        end
        ST_EXEC: begin
          if (step == last_step) begin
            state       <= ST_WAIT;
            o_ins_ready <= 1'b1;
          end else begin
            step <= step + 3'h1;
          end
        end
        default: begin
          state       <= ST_WAIT;
          o_ins_ready <= 1'b1;
        end
      endcase
    end
  end

  // Operand capture; SFR bytes held in flops override the RAM
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      opnd0 <= 8'h00;
      opnd1 <= 8'h00;
    end else if (state == ST_EXEC) begin
      if (step == STEP_RD1) begin
        opnd0 <= sfr_acc ? o_acc : (sfr_st ? o_status_word : m_rdata);
      end
      if (step == STEP_BIT_WR) begin
        opnd1 <= m_rdata;
      end
    end
  end

  // External data bus; strobes span three clocks, from the last clock of the first cycle to the second clock of the second
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_xd <= '0;
      xcap <= 8'h00;
    end else if (state == ST_EXEC) begin
      if ((step == STEP_XD_ON) && is_xmove) begin
        o_xd.rd    <= xd_rd; // RQ4
        o_xd.wr    <= xd_wr;
        o_xd.addr  <= xd_dp ? o_data_ptr : {8'h00, m_rdata}; // RQ1
        o_xd.wdata <= o_acc; // RQ3
      end
      if (step == STEP_XD_OFF) begin
        o_xd.rd <= 1'b0;
        o_xd.wr <= 1'b0;
        if (o_xd.rd) begin
          xcap <= i_xd_rdata;
        end
      end
    end
  end

  // Program memory constant read, never a write
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_code_rd   <= 1'b0;
      o_code_addr <= 16'h0000;
      ccap        <= 8'h00;
    end else begin
      o_code_rd <= (state == ST_EXEC) && (step == STEP_CODE_RQ) && is_ccr;
      if ((state == ST_EXEC) && (step == STEP_CODE_RQ) && is_ccr) begin
        o_code_addr <= {8'h00, o_acc} + ((op == OP_CCR_DP) ? o_data_ptr : pc_next); // RQ5
      end
      if ((state == ST_EXEC) && (step == STEP_CODE_CAP)) begin
        ccap <= i_code_data;
      end
    end
  end

  // Accumulator
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_acc <= 8'h00;
    end else if ((state == ST_EXEC) && (step == STEP_BIT_WR) && bit_wr && sfr_acc) begin
      o_acc <= byte_new;
    end else if ((state == ST_EXEC) && (step == STEP_DEC_WR) && is_dec && sfr_acc) begin
      o_acc <= dec_val;
    end else if (commit && xd_rd) begin
      o_acc <= xcap; // RQ3
    end else if (commit && is_ccr) begin
      o_acc <= ccap; // RQ5
    end
  end

  // Status word; instruction results touch only carry, except bit or decrement ops addressing the status byte
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_status_word <= 8'h00;
    end else if ((state == ST_EXEC) && (step == STEP_BIT_WR) && bit_wr && sfr_st) begin
      o_status_word <= byte_new;
    end else if ((state == ST_EXEC) && (step == STEP_DEC_WR) && is_dec && sfr_st) begin
      o_status_word <= dec_val;
    end else if (commit) begin
      o_status_word[ST_CY] <= next_cy; // RQ7 RQ19 RQ21
    end
  end

  // Program counter, stack pointer, data pointer, interrupt-done pulse
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pc       <= 16'h0000;
      o_sp       <= SP_RESET;
      o_int_done <= 1'b0;
    end else begin
      o_int_done <= commit && (op == OP_INT_RTN); // RQ16
      if (commit) begin
        o_pc <= next_pc;
        if (is_call) begin
          o_sp <= o_sp + SP_PAIR;
        end else if (is_rtn) begin
          o_sp <= o_sp - SP_PAIR;
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_data_ptr <= 16'h0000;
    end else if (i_data_ptr_ld) begin
      o_data_ptr <= i_data_ptr;
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  sequence s_two_cyc;
    (!o_ins_ready) [*6] ##1 o_ins_ready;
  endsequence
  sequence s_one_cyc;
    (!o_ins_ready) [*3] ##1 o_ins_ready;
  endsequence

  a_xd_addr_src: assert property ((o_xd.rd || o_xd.wr) |-> // RQ1
    o_xd.addr == (xd_dp ? o_data_ptr : {8'h00, opnd0}))
    else $error("external address not from index register or data pointer");
  a_xd_two_cyc: assert property ((state == ST_EXEC) && (step == STEP_RD0) && is_xmove // RQ2
    |-> s_two_cyc)
    else $error("external data move not two machine cycles");
  a_xd_acc_data: assert property ($fell(o_xd.rd) |=> o_acc == $past(i_xd_rdata, 2)) // RQ3
    else $error("external read did not land in accumulator");
  a_xd_strobe_gate: assert property ((o_xd.rd || o_xd.wr) |-> // RQ4
    (state == ST_EXEC) && is_xmove && (o_xd.wdata == o_acc))
    else $error("external strobe outside an external data move");
  a_code_addr_sum: assert property (o_code_rd |-> // RQ5
    o_code_addr == {8'h00, o_acc} + ((op == OP_CCR_DP) ? o_data_ptr : pc_next))
    else $error("code read address wrong");
  a_bit_one_cyc: assert property ((state == ST_EXEC) && (step == STEP_RD0) && one_cyc // RQ20
    |-> s_one_cyc)
    else $error("one-cycle instruction took the wrong time");
  a_carry_and_bit: assert property (commit && (op == OP_AND_C_BIT) |=> // RQ7
    o_status_word[ST_CY] == ($past(cy) & $past(bv)))
    else $error("carry and-bit result wrong");
  a_bitclr_acc: assert property ((state == ST_EXEC) && (step == STEP_BIT_WR) // RQ9
    && (op == OP_JMP_BITCLR) && bv && sfr_acc |=> !o_acc[$past(bit_idx)])
    else $error("tested bit not cleared");
  a_rel_target: assert property (commit && taken |=> o_pc == $past(rel_target)) // RQ10
    else $error("relative branch target wrong");
  a_abs_page_keep: assert property (commit && is_abs |=> // RQ13
    o_pc[15:11] == $past(pc_next[15:11]))
    else $error("page jump changed upper program counter bits");
  a_cmp_carry: assert property (commit && is_cmp |=> // RQ19
    o_status_word[ST_CY] == $past(cmp_a < cmp_b))
    else $error("compare carry wrong");
  a_dec_flags_kept: assert property (commit && is_dec && !sfr_st |=> // RQ21
    $stable(o_status_word))
    else $error("decrement branch changed flags");
  a_int_done_pulse: assert property (commit && (op == OP_INT_RTN) |=> // RQ16
    o_int_done ##1 !o_int_done)
    else $error("interrupt done not a single pulse");
endmodule : cbx_exec

// ==== testbench/cbx_mem_model.sv ====
`timescale 1ns/1ps
module cbx_mem_model
  import cbx_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // Program memory
  input  wire logic        i_code_rd,
  input  wire logic [15:0] i_code_addr,
  output logic      [7:0]  o_code_data,
  // External data memory
  input  wire cbx_xbus_t   i_xd,
  output logic      [7:0]  o_xd_rdata
);
  logic [7:0] xmem [0:65535];
  logic       tog;
  // Program bytes follow a fixed pattern; between reads the bus wanders
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tog         <= 1'b0;
      o_code_data <= 8'h00;
    end else begin
      tog         <= ~tog;
      o_code_data <= i_code_rd ? (i_code_addr[7:0] ^ i_code_addr[15:8] ^ 8'h5a) : {8{tog}};
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_xd.wr) begin
      xmem[i_xd.addr] <= i_xd.wdata;
    end
  end
  // Released data lines show a changing pattern, never the last value
  assign o_xd_rdata = i_xd.rd ? xmem[i_xd.addr] : {8{tog}};
endmodule : cbx_mem_model

// ==== testbench/cbx_exec_bench.sv ====
`timescale 1ns/1ps
module cbx_exec_bench;
  import cbx_pkg::*;
  logic        i_clk = 1'b0, i_rst_n = 1'b0, i_ins_valid = 1'b0, i_data_ptr_ld = 1'b0;
  cbx_ins_t    i_ins = '0;
  logic [15:0] i_data_ptr = 16'h0130, o_code_addr, o_pc, o_data_ptr, pc = 16'h0000, r;
  logic [7:0]  i_code_data, i_xd_rdata, o_acc, o_status_word, o_sp, v;
  logic        o_ins_ready, o_code_rd, o_int_done, fin;
  cbx_xbus_t   o_xd;
  int          err_count = 0, num_checks = 0, cyc = 0;
  cbx_exec dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ins_valid(i_ins_valid), .i_ins(i_ins),
    .o_ins_ready(o_ins_ready), .i_data_ptr_ld(i_data_ptr_ld), .i_data_ptr(i_data_ptr),
    .o_code_rd(o_code_rd), .o_code_addr(o_code_addr), .i_code_data(i_code_data), .o_xd(o_xd),
    .i_xd_rdata(i_xd_rdata), .o_pc(o_pc), .o_acc(o_acc), .o_status_word(o_status_word),
    .o_sp(o_sp), .o_data_ptr(o_data_ptr), .o_int_done(o_int_done));
  cbx_mem_model mem (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_code_rd(o_code_rd),
    .i_code_addr(o_code_addr), .o_code_data(i_code_data), .i_xd(o_xd), .o_xd_rdata(i_xd_rdata));
  always #2 i_clk = ~i_clk;
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      wrap_up();
    end
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, exp, seen);
    end
  endtask : chk
  function automatic logic [15:0] rel(input int len, input logic [7:0] off);
    return pc + 16'(len) + {{8{off[7]}}, off};
  endfunction : rel
  function automatic logic [7:0] cpat(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction : cpat
  // Offers one instruction, counts the busy cycles and checks where the PC lands
  task automatic run(input logic [7:0] op, b1, b2, input int ncyc, input logic [15:0] nxt);
    int n;
    n = 0;
    i_ins = '{op, b1, b2};
    i_ins_valid = 1'b1;
    @(posedge i_clk);
    #1;
    i_ins_valid = 1'b0;
    while (o_ins_ready !== 1'b1 && n < 10) begin
      n++;
      @(posedge i_clk);
      #1;
    end
    fin = o_int_done;
    chk("cycles", 16'(n), 16'(CLKS_PER_CYCLE * ncyc));
    chk("pc", o_pc, nxt);
    chk("strobes", 16'({o_xd.rd, o_xd.wr}), 16'h0000);
    pc = nxt;
  endtask : run
  task automatic t_reset;
    chk("ready", 16'(o_ins_ready), 16'h0001);
    chk("pc", o_pc, 16'h0000);
    chk("acc", 16'(o_acc), 16'h0000);
    chk("sp", 16'(o_sp), 16'h0007);
    chk("strobes", 16'({o_xd.rd, o_xd.wr}), 16'h0000);
    i_data_ptr_ld = 1'b1;
    @(posedge i_clk);
    #1;
    i_data_ptr_ld = 1'b0;
    chk("data_ptr", o_data_ptr, 16'h0130);
    $display("done reset");
  endtask : t_reset
  task automatic t_bits;
    run(OP_SET_C, 8'h00, 8'h00, 1, pc + 1);
    chk("carry", 16'(o_status_word[7]), 16'h0001);
    run(OP_INV_C, 8'h00, 8'h00, 1, pc + 1);
    chk("carry", 16'(o_status_word[7]), 16'h0000);
    run(OP_JMP_NCY, 8'hfc, 8'h00, 2, rel(2, 8'hfc));
    run(OP_SET_BIT, 8'he0, 8'h00, 1, pc + 2);
    chk("acc", 16'(o_acc), 16'h0001);
    run(OP_JMP_BITCLR, 8'he0, 8'h08, 2, rel(3, 8'h08));
    chk("acc", 16'(o_acc), 16'h0000);
    run(OP_SET_BIT, 8'he0, 8'h00, 1, pc + 2);
    run(OP_SET_BIT, 8'h05, 8'h00, 1, pc + 2);
    run(OP_JMP_BITCLR, 8'h05, 8'h08, 2, rel(3, 8'h08));
    run(OP_JMP_BITCLR, 8'h05, 8'h08, 2, pc + 3);
    run(OP_SET_C, 8'h00, 8'h00, 1, pc + 1);
    run(OP_AND_C_NBIT, 8'h05, 8'h00, 1, pc + 2);
    chk("carry", 16'(o_status_word[7]), 16'h0001);
    run(OP_AND_C_BIT, 8'h05, 8'h00, 1, pc + 2);
    chk("carry", 16'(o_status_word[7]), 16'h0000);
    run(OP_MOV_C_BIT, 8'he0, 8'h00, 1, pc + 2);
    chk("carry", 16'(o_status_word[7]), 16'h0001);
    $display("done bits");
  endtask : t_bits
  task automatic t_acc;
    run(OP_JMP_ACCZ, 8'h05, 8'h00, 2, pc + 2);
    run(OP_JMP_ACCNZ, 8'h05, 8'h00, 2, rel(2, 8'h05));
    run(OP_CMP_BR_AIMM, 8'h02, 8'h10, 2, rel(3, 8'h10));
    chk("carry", 16'(o_status_word[7]), 16'h0001);
    run(OP_CMP_BR_AIMM, 8'h01, 8'h10, 2, pc + 3);
    chk("carry", 16'(o_status_word[7]), 16'h0000);
    run(OP_DEC_BR_DIR, 8'he0, 8'h03, 2, pc + 3);
    chk("acc", 16'(o_acc), 16'h0000);
    run(OP_SET_C, 8'h00, 8'h00, 1, pc + 1);
    run(OP_DEC_BR_DIR, 8'he0, 8'h03, 2, rel(3, 8'h03));
    chk("acc", 16'(o_acc), 16'h00ff);
    chk("carry", 16'(o_status_word[7]), 16'h0001);
    $display("done acc");
  endtask : t_acc
  task automatic t_mem;
    v = cpat(16'h022f);
    run(OP_CCR_DP, 8'h00, 8'h00, 2, pc + 1);
    chk("code_addr", o_code_addr, 16'h022f);
    chk("acc", 16'(o_acc), 16'(v));
    run(OP_XD_WR_DP, 8'h00, 8'h00, 2, pc + 1);
    chk("xaddr", o_xd.addr, 16'h0130);
    chk("xdata", 16'(o_xd.wdata), 16'(v));
    run(OP_SET_BIT, 8'he7, 8'h00, 1, pc + 2);
    run(OP_XD_RD_DP, 8'h00, 8'h00, 2, pc + 1);
    chk("acc", 16'(o_acc), 16'(v));
    run(OP_JMP_IND, 8'h00, 8'h00, 2, 16'h0130 + 16'(v));
    r = pc + 16'h0001 + 16'(v);
    run(OP_CCR_PC, 8'h00, 8'h00, 2, pc + 1);
    chk("acc", 16'(o_acc), 16'(cpat(r)));
    chk("code_addr", o_code_addr, r);
    $display("done mem");
  endtask : t_mem
  task automatic t_jumps;
    run(OP_JMP_LONG, 8'h12, 8'h34, 2, 16'h1234);
    run(8'he1, 8'hf5, 8'h00, 2, 16'h17f5);
    run(OP_JMP_SHORT, 8'h80, 8'h00, 2, rel(2, 8'h80));
    r = pc + 16'h0003;
    run(OP_CALL_LONG, 8'h20, 8'h00, 2, 16'h2000);
    chk("sp", 16'(o_sp), 16'h0009);
    run(8'h31, 8'h10, 8'h00, 2, 16'h2110);
    chk("sp", 16'(o_sp), 16'h000b);
    run(OP_SUB_RTN, 8'h00, 8'h00, 2, 16'h2002);
    run(OP_INT_RTN, 8'h00, 8'h00, 2, r);
    chk("sp", 16'(o_sp), 16'h0007);
    chk("int_done", 16'(fin), 16'h0001);
    run(OP_NO_OP, 8'h00, 8'h00, 1, pc + 1);
    $display("done jumps");
  endtask : t_jumps
  initial begin
    repeat (16) @(posedge i_clk);
    #1;
    i_rst_n = 1'b1;
    @(posedge i_clk);
    #1;
    t_reset();
    t_bits();
    t_acc();
    t_mem();
    t_jumps();
    wrap_up();
  end
endmodule : cbx_exec_bench
